// file: bmp_pkg.sv
// package: operation codes and fixed widths for the bit-manipulation datapath unit
package bmp_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned WORD_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned BASE32_XLEN = 32;
  localparam int unsigned DEFAULT_XLEN = 32;

  // ==========================================================================
  // scale shifts for the index-plus-base adds
  localparam logic [1:0] SH_SCALE2 = 2'h1;
  localparam logic [1:0] SH_SCALE4 = 2'h2;
  localparam logic [1:0] SH_SCALE8 = 2'h3;

  // ==========================================================================
  // low bits appended to a lookup index to turn it into a bit offset
  localparam logic [2:0] BYTE_IDX_PAD = 3'h0;
  localparam logic [1:0] NIB_IDX_PAD = 2'h0;

  // ==========================================================================
  // decoded operation select
  typedef enum logic [3:0] {
    OP_WORD_SCALE2_ADD,
    OP_SCALE4_ADD,
    OP_WORD_SCALE4_ADD,
    OP_SCALE8_ADD,
    OP_WORD_SCALE8_ADD,
    OP_WORD_IMM_LEFT_SHIFT,
    OP_DEINTERLEAVE,
    OP_XNOR,
    OP_BYTE_LOOKUP,
    OP_NIB_LOOKUP,
    OP_ZEXT_HALF
  } bmp_op_t;

endpackage

// file: bmp_perm_if.sv
// interface: table, index vector and lookup results between the unit and its permute lanes
`timescale 1ns/1ps
interface bmp_perm_if #(
  parameter int unsigned XLEN = 32
);
  logic [XLEN-1:0] table_w;
  logic [XLEN-1:0] index_w;
  logic [XLEN-1:0] byte_res;
  logic [XLEN-1:0] nib_res;

  modport req (output table_w, output index_w, input byte_res, input nib_res);
  modport rsp (input table_w, input index_w, output byte_res, output nib_res);
endinterface

// file: bmp_scaled_add.sv
// scaled index-plus-base adder, full-width or zero-extended low-word index
`timescale 1ns/1ps
module bmp_scaled_add
  import bmp_pkg::*;
#(
  parameter int unsigned XLEN = 32
) (
  input wire logic [XLEN-1:0] base_i,  // addend taken as is
  input wire logic [XLEN-1:0] index_i, // addend that is scaled
  input wire logic word_i,             // use only the low word of the index
  input wire logic [1:0] shift_i,      // scale as a left shift
  output logic [XLEN-1:0] sum_o        // register-width sum
);

  logic [XLEN-1:0] index_ext;

  always_comb begin
    // zero-extension happens before the shift so bits above 31 can appear
    if (word_i) begin
      index_ext = XLEN'(index_i[WORD_W-1:0]);
    end else begin
      index_ext = index_i;
    end
    sum_o = base_i + (index_ext << shift_i); // carry out is dropped, as for any add
  end

endmodule

// file: bmp_perm_lanes.sv
// byte-wise and nibble-wise table lookup lanes
`timescale 1ns/1ps
module bmp_perm_lanes
  import bmp_pkg::*;
#(
  parameter int unsigned XLEN = 32
) (
  bmp_perm_if.rsp lut // table and index in, both lookup results out
);

  // ==========================================================================
  // byte lanes: a shift by the index times eight runs off the table when the
  // index is out of range, so the zero answer needs no separate compare
  for (genvar b = 0; b < XLEN / BYTE_W; b++) begin : g_byte
    logic [XLEN-1:0] shifted;
    assign shifted = lut.table_w >> {lut.index_w[b*BYTE_W +: BYTE_W], BYTE_IDX_PAD};
    assign lut.byte_res[b*BYTE_W +: BYTE_W] = shifted[BYTE_W-1:0];
  end

  // ==========================================================================
  // nibble lanes
  for (genvar n = 0; n < XLEN / NIB_W; n++) begin : g_nib
    logic [XLEN-1:0] shifted;
    assign shifted = lut.table_w >> {lut.index_w[n*NIB_W +: NIB_W], NIB_IDX_PAD};
    assign lut.nib_res[n*NIB_W +: NIB_W] = shifted[NIB_W-1:0];
  end

endmodule

// file: bmp_unit.sv
// top: bit-manipulation datapath unit with one registered result stage
// Notes on behaviour
// - word scale-by-two add: zero-extend low word of first source, shift 1, add second.
// - scale-by-four add: whole first source shifted left 2, plus second source.
// - word scale-by-four add: zero-extended low word shifted left 2, plus second source.
// - scale-by-eight add: whole first source shifted left 3, plus second source.
// - word scale-by-eight add: zero-extended low word shifted left 3, plus second.
// - word immediate shift: zero-extended low word shifted left by the immediate.
// - de-interleave: even source bits to low half, odd bits to high half.
// - de-interleave exists only for the 32-bit base; refused at 64 bits.
// - exclusive-NOR: complement of bitwise XOR of both sources, full width.
// - byte lookup: first source is a byte table, out-of-range index gives zero.
// - byte lookup lane: table shifted right by index times eight, low byte kept.
// - nibble lookup: first source is a nibble table, out-of-range index gives zero.
// - nibble lookup lane: table shifted right by index times four, low nibble kept.
// - halfword zero-extend: low sixteen bits pass, all higher bits zero.
`timescale 1ns/1ps
module bmp_unit
  import bmp_pkg::*;
#(
  parameter int unsigned XLEN = DEFAULT_XLEN,
  parameter int unsigned SHAMT_W = $clog2(XLEN)
) (
  input wire logic clock_i,                     // 20 MHz clock
  input wire logic rst_n_i,                     // asynchronous reset, active low
  input wire logic valid_i,                     // operation presented this cycle
  input wire bmp_op_t op_i,                     // decoded operation select
  input wire logic [XLEN-1:0] first_source_operand_i,  // first source operand
  input wire logic [XLEN-1:0] second_source_operand_i, // second source operand
  input wire logic [SHAMT_W-1:0] shamt_i,       // immediate shift amount
  output logic valid_o,                         // result valid, one cycle after valid_i
  output logic [XLEN-1:0] result_o,             // registered result
  output logic illegal_o                        // operation refused, result is zero
);

  localparam int unsigned HALF_X = XLEN / 2;

  // ==========================================================================
  // state
  typedef struct packed {
    logic valid;
    logic illegal;
    logic [XLEN-1:0] result;
  } bmp_state_t;

  bmp_state_t state_q;
  bmp_state_t state_d;

  // ==========================================================================
  // shared datapath pieces
  logic [XLEN-1:0] add_sum;
  logic add_word;
  logic [1:0] add_shift;
  logic [XLEN-1:0] deint;

  bmp_perm_if #(.XLEN(XLEN)) perm ();

  assign perm.table_w = first_source_operand_i;
  assign perm.index_w = second_source_operand_i;

  bmp_perm_lanes #(.XLEN(XLEN)) u_perm (
    .lut (perm.rsp)
  );

  bmp_scaled_add #(.XLEN(XLEN)) u_add (
    .base_i  (second_source_operand_i),
    .index_i (first_source_operand_i),
    .word_i  (add_word),
    .shift_i (add_shift),
    .sum_o   (add_sum)
  );

  // one adder serves all five scaled adds; only its controls change with the op
  always_comb begin
    add_word = 1'b0;
    add_shift = SH_SCALE2;
    unique case (op_i)
      OP_WORD_SCALE2_ADD: begin
        add_word = 1'b1;
        add_shift = SH_SCALE2;
      end
      OP_SCALE4_ADD: begin
        add_shift = SH_SCALE4;
      end
      OP_WORD_SCALE4_ADD: begin
        add_word = 1'b1;
        add_shift = SH_SCALE4;
      end
      OP_SCALE8_ADD: begin
        add_shift = SH_SCALE8;
      end
      OP_WORD_SCALE8_ADD: begin
        add_word = 1'b1;
        add_shift = SH_SCALE8;
      end
      default: begin
        add_word = 1'b0;
        add_shift = SH_SCALE2;
      end
    endcase
  end

  always_comb begin
    deint = '0;
    for (int i = 0; i < HALF_X; i++) begin
      deint[i] = first_source_operand_i[2*i];
      deint[i+HALF_X] = first_source_operand_i[2*i+1];
    end
  end

  // ==========================================================================
  // next state: the whole result is formed in this cycle, the flop only holds it
  always_comb begin
    state_d = '0;
    state_d.valid = valid_i;
    if (valid_i) begin
      unique case (op_i)
        OP_WORD_SCALE2_ADD, OP_SCALE4_ADD, OP_WORD_SCALE4_ADD,
        OP_SCALE8_ADD, OP_WORD_SCALE8_ADD: begin
          state_d.result = add_sum;
        end
        OP_WORD_IMM_LEFT_SHIFT: begin
          state_d.result = XLEN'(first_source_operand_i[WORD_W-1:0]) << shamt_i;
        end
        OP_DEINTERLEAVE: begin
          // wider cores do not offer it; answer zero and flag the refusal
          if (XLEN == BASE32_XLEN) begin
            state_d.result = deint;
          end else begin
            state_d.illegal = 1'b1;
          end
        end
        OP_XNOR: begin
          state_d.result = ~(first_source_operand_i ^ second_source_operand_i);
        end
        OP_BYTE_LOOKUP: begin
          state_d.result = perm.byte_res;
        end
        OP_NIB_LOOKUP: begin
          state_d.result = perm.nib_res;
        end
        OP_ZEXT_HALF: begin
          state_d.result = XLEN'(first_source_operand_i[HALF_W-1:0]);
        end
        default: begin
          state_d.illegal = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign valid_o = state_q.valid;
  assign result_o = state_q.result;
  assign illegal_o = state_q.illegal;

  // ==========================================================================
  // checks
  word_scale2_add_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == OP_WORD_SCALE2_ADD |=> valid_o && !illegal_o &&
      result_o == $past(second_source_operand_i) +
        (XLEN'($past(first_source_operand_i[WORD_W-1:0])) << 1))
    else $error("word scale-by-two add result wrong");

  scale4_add_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == OP_SCALE4_ADD |=>
      result_o == $past(second_source_operand_i) + ($past(first_source_operand_i) << 2))
    else $error("scale-by-four add result wrong");

  word_scale4_add_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == OP_WORD_SCALE4_ADD |=>
      result_o == $past(second_source_operand_i) +
        (XLEN'($past(first_source_operand_i[WORD_W-1:0])) << 2))
    else $error("word scale-by-four add result wrong");

  scale8_add_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == OP_SCALE8_ADD |=>
      result_o == $past(second_source_operand_i) + ($past(first_source_operand_i) << 3))
    else $error("scale-by-eight add result wrong");

  word_scale8_add_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == OP_WORD_SCALE8_ADD |=>
      result_o == $past(second_source_operand_i) +
        (XLEN'($past(first_source_operand_i[WORD_W-1:0])) << 3))
    else $error("word scale-by-eight add result wrong");

  word_imm_shift_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == OP_WORD_IMM_LEFT_SHIFT |=>
      result_o == (XLEN'($past(first_source_operand_i[WORD_W-1:0])) << $past(shamt_i)))
    else $error("word immediate shift result wrong");

  deint_bits_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == OP_DEINTERLEAVE && XLEN == BASE32_XLEN |=>
      result_o[0] == $past(first_source_operand_i[0]) &&
      result_o[HALF_X] == $past(first_source_operand_i[1]) &&
      result_o[HALF_X-1] == $past(first_source_operand_i[XLEN-2]) &&
      result_o[XLEN-1] == $past(first_source_operand_i[XLEN-1]))
    else $error("de-interleave bit placement wrong");

  deint_refuse_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == OP_DEINTERLEAVE |=>
      illegal_o == (XLEN != BASE32_XLEN) && (!illegal_o || result_o == '0))
    else $error("de-interleave width check wrong");

  xnor_result_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == OP_XNOR |=>
      (result_o ^ $past(first_source_operand_i) ^ $past(second_source_operand_i)) == '1)
    else $error("exclusive-NOR result wrong");

  byte_lookup_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == OP_BYTE_LOOKUP |=>
      result_o[BYTE_W-1:0] == (($past(second_source_operand_i[BYTE_W-1:0]) < XLEN / BYTE_W) ?
        BYTE_W'($past(first_source_operand_i) >>
          ($past(second_source_operand_i[BYTE_W-1:0]) * BYTE_W)) : '0))
    else $error("byte lookup lane zero wrong");

  nib_lookup_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == OP_NIB_LOOKUP |=>
      result_o[XLEN-1 -: NIB_W] == (($past(second_source_operand_i[XLEN-1 -: NIB_W]) <
        XLEN / NIB_W) ? NIB_W'($past(first_source_operand_i) >>
          ($past(second_source_operand_i[XLEN-1 -: NIB_W]) * NIB_W)) : '0))
    else $error("nibble lookup top lane wrong");

  zext_half_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == OP_ZEXT_HALF |=>
      result_o[HALF_W-1:0] == $past(first_source_operand_i[HALF_W-1:0]) &&
      (result_o >> HALF_W) == '0)
    else $error("halfword zero-extension wrong");

  // an op sampled while reset was low never reaches the stage, which reset holds clear
  result_latency_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_o == ($past(valid_i) && $past(rst_n_i)))
    else $error("result stage timing wrong");

  idle_zero_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !valid_o |-> result_o == '0 && !illegal_o)
    else $error("idle result not cleared");

  // ==========================================================================
  // refusals, adder controls, lane-by-lane lookups and de-interleave
  bad_code_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && 4'(op_i) > 4'(OP_ZEXT_HALF) |=> valid_o && illegal_o && result_o == '0)
    else $error("unknown operation not refused");

  legal_op_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && 4'(op_i) <= 4'(OP_ZEXT_HALF) && op_i != OP_DEINTERLEAVE |=>
      valid_o && !illegal_o)
    else $error("legal operation refused");

  word_add_ctrl_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i inside {OP_WORD_SCALE2_ADD, OP_WORD_SCALE4_ADD, OP_WORD_SCALE8_ADD} |->
      add_word)
    else $error("word add does not zero-extend its index");

  full_add_ctrl_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i inside {OP_SCALE4_ADD, OP_SCALE8_ADD} |-> !add_word)
    else $error("full-width add cuts its index");

  byte_range_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == OP_BYTE_LOOKUP &&
      second_source_operand_i[XLEN-1 -: BYTE_W] >= XLEN / BYTE_W |=>
      result_o[XLEN-1 -: BYTE_W] == '0)
    else $error("byte index out of range not zero");

  nib_range_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == OP_NIB_LOOKUP &&
      second_source_operand_i[XLEN-1 -: NIB_W] >= XLEN / NIB_W |=>
      result_o[XLEN-1 -: NIB_W] == '0)
    else $error("nibble index out of range not zero");

  // every lane, not just the ends: a wrong lane slice would pass the single-lane checks
  for (genvar b = 0; b < XLEN / BYTE_W; b++) begin : g_byte_chk
    byte_lane_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      valid_i && op_i == OP_BYTE_LOOKUP |=>
        result_o[b*BYTE_W +: BYTE_W] ==
          (($past(second_source_operand_i[b*BYTE_W +: BYTE_W]) < XLEN / BYTE_W) ?
            BYTE_W'($past(first_source_operand_i) >>
              ($past(second_source_operand_i[b*BYTE_W +: BYTE_W]) * BYTE_W)) : '0))
      else $error("byte lookup lane wrong");
  end

  for (genvar n = 0; n < XLEN / NIB_W; n++) begin : g_nib_chk
    nib_lane_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      valid_i && op_i == OP_NIB_LOOKUP |=>
        result_o[n*NIB_W +: NIB_W] ==
          (($past(second_source_operand_i[n*NIB_W +: NIB_W]) < XLEN / NIB_W) ?
            NIB_W'($past(first_source_operand_i) >>
              ($past(second_source_operand_i[n*NIB_W +: NIB_W]) * NIB_W)) : '0))
      else $error("nibble lookup lane wrong");
  end

  for (genvar d = 0; d < HALF_X; d++) begin : g_deint_chk
    deint_lane_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      valid_i && op_i == OP_DEINTERLEAVE && XLEN == BASE32_XLEN |=>
        result_o[d] == $past(first_source_operand_i[2*d]) &&
        result_o[d+HALF_X] == $past(first_source_operand_i[2*d+1]))
      else $error("de-interleave bit wrong");
  end

endmodule

// file: bmp_core_model.sv
// partner: core side that presents decoded operations and operands to the unit
`timescale 1ns/1ps
module bmp_core_model
  import bmp_pkg::*;
(
  output logic valid_o,         // operation presented
  output bmp_op_t op_o,         // decoded operation select
  output logic [63:0] first_o,  // first source operand, widest case
  output logic [63:0] second_o, // second source operand, widest case
  output logic [5:0] shamt_o    // immediate shift amount
);
  initial begin
    valid_o = 1'b0;
    op_o = OP_XNOR;
    first_o = 64'h0;
    second_o = 64'h0;
    shamt_o = 6'h0;
  end

  // ==========================================================================
  // drive
  task automatic present(input bmp_op_t o, input logic [63:0] a, b, input logic [5:0] s);
    valid_o = 1'b1;
    op_o = o;
    first_o = a;
    second_o = b;
    shamt_o = s;
  endtask

  // idle operands flip so a stale value can never pass for a held one
  task automatic idle();
    valid_o = 1'b0;
    first_o = ~first_o;
    second_o = ~second_o;
  endtask
endmodule

// file: bmp_unit_test.sv
// testbench: both widths of the unit driven side by side against a reference model
`timescale 1ns/1ps
module bmp_unit_test;
  import bmp_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic valid, v32, i32, v64, i64, pend;
  bmp_op_t op;
  logic [63:0] fa, sb, r64;
  logic [31:0] r32;
  logic [5:0] sh;
  logic [64:0] e32, e64;
  string pname;
  int miscompares = 0;
  int checks_done = 0;

  initial begin
    forever #25 clock_i = ~clock_i;
  end

  bmp_core_model core (.valid_o(valid), .op_o(op), .first_o(fa), .second_o(sb), .shamt_o(sh));

  bmp_unit #(.XLEN(32)) uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .valid_i(valid), .op_i(op),
    .first_source_operand_i(fa[31:0]), .second_source_operand_i(sb[31:0]), .shamt_i(sh[4:0]),
    .valid_o(v32), .result_o(r32), .illegal_o(i32));
  bmp_unit #(.XLEN(64)) uut_wide (.clock_i(clock_i), .rst_n_i(rst_n_i), .valid_i(valid),
    .op_i(op), .first_source_operand_i(fa), .second_source_operand_i(sb), .shamt_i(sh),
    .valid_o(v64), .result_o(r64), .illegal_o(i64));

  // ==========================================================================
  // reference: bit 64 is the refusal flag
  function automatic logic [64:0] model(input bmp_op_t o, input logic [63:0] a, b,
                                        input logic [5:0] s, input int xl);
    logic [63:0] m, w, r;
    logic bad;
    int idx;
    m = (xl == 64) ? 64'hFFFFFFFFFFFFFFFF : 64'hFFFFFFFF;
    a = a & m;
    b = b & m;
    w = a & 64'hFFFFFFFF;
    r = 64'h0;
    bad = 1'b0;
    case (o)
      OP_WORD_SCALE2_ADD: r = b + (w << 1);
      OP_SCALE4_ADD: r = b + (a << 2);
      OP_WORD_SCALE4_ADD: r = b + (w << 2);
      OP_SCALE8_ADD: r = b + (a << 3);
      OP_WORD_SCALE8_ADD: r = b + (w << 3);
      OP_WORD_IMM_LEFT_SHIFT: r = w << (s & (xl - 1));
      OP_DEINTERLEAVE: begin
        if (xl == 32) begin
          for (int i = 0; i < 16; i++) begin
            r[i] = a[2*i];
            r[i+16] = a[2*i+1];
          end
        end else begin
          bad = 1'b1;
        end
      end
      OP_XNOR: r = ~(a ^ b);
      OP_BYTE_LOOKUP: begin
        for (int k = 0; k < xl / 8; k++) begin
          idx = b[8*k+:8];
          r[8*k+:8] = (idx < xl / 8) ? a[8*idx+:8] : 8'h0;
        end
      end
      OP_NIB_LOOKUP: begin
        for (int k = 0; k < xl / 4; k++) begin
          idx = b[4*k+:4];
          r[4*k+:4] = (idx < xl / 4) ? a[4*idx+:4] : 4'h0;
        end
      end
      OP_ZEXT_HALF: r = {48'h0, a[15:0]};
      default: bad = 1'b1;
    endcase
    return bad ? {1'b1, 64'h0} : {1'b0, r & m};
  endfunction

  // ==========================================================================
  // compare and drive
  task automatic check(input string n, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic settle();
    if (pend) begin
      check({pname, " valid"}, 64'h1, {63'h0, v32});
      check({pname, " refused"}, {63'h0, e32[64]}, {63'h0, i32});
      check({pname, " result"}, e32[63:0], {32'h0, r32});
      check({pname, " wide valid"}, 64'h1, {63'h0, v64});
      check({pname, " wide refused"}, {63'h0, e64[64]}, {63'h0, i64});
      check({pname, " wide result"}, e64[63:0], r64);
    end
    pend = 1'b0;
  endtask

  // each call is taken on the next rising edge; calls in a row run back to back
  task automatic run(input bmp_op_t o, input logic [63:0] a, b, input logic [5:0] s,
                     input string n);
    @(negedge clock_i);
    settle();
    core.present(o, a, b, s);
    e32 = model(o, a, b, s, 32);
    e64 = model(o, a, b, s, 64);
    pname = n;
    pend = 1'b1;
  endtask

  // with no request the outputs fall back to zero
  task automatic done();
    @(negedge clock_i);
    settle();
    core.idle();
    @(negedge clock_i);
    check("idle valid", 64'h0, {63'h0, v32});
    check("idle result", 64'h0, {32'h0, r32});
  endtask

  task automatic t_reset();
    run(OP_XNOR, 64'h0, 64'h0, 6'h0, "before reset");
    @(negedge clock_i);
    settle();
    rst_n_i = 1'b0;
    #1;
    check("reset valid", 64'h0, {63'h0, v64});
    check("reset result", 64'h0, r64);
    check("reset refused", 64'h0, {63'h0, i64});
    check("reset narrow valid", 64'h0, {63'h0, v32});
    @(negedge clock_i);
    rst_n_i = 1'b1;
    core.idle();
  endtask

  task automatic stop_test();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  initial begin
    pend = 1'b0;
    repeat (20) @(negedge clock_i);
    rst_n_i = 1'b1;
    for (int k = 0; k < 5; k++) begin
      run(bmp_op_t'(k), 64'hF0000001C0000003, 64'hFFFFFFFFFFFFFFF0, 6'h0, "add");
    end
    run(OP_WORD_IMM_LEFT_SHIFT, 64'hFFFFFFFF80000001, 64'h0, 6'h1F, "shift max");
    run(OP_WORD_IMM_LEFT_SHIFT, 64'hFFFFFFFF80000001, 64'h0, 6'h0, "shift zero");
    run(OP_DEINTERLEAVE, 64'h12345678C3A5F00D, 64'h0, 6'h0, "deinterleave");
    run(OP_XNOR, 64'hFF00A5A50F0F1234, 64'h0FF05A5AFFFF4321, 6'h0, "xnor");
    run(OP_BYTE_LOOKUP, 64'h8877665544332211, 64'h00070803FF000102, 6'h0, "byte lut");
    run(OP_NIB_LOOKUP, 64'hFEDCBA9876543210, 64'h0F8F1234F7A05C16, 6'h0, "nib lut");
    run(OP_ZEXT_HALF, 64'hFFFFFFFFFFFF8001, 64'h0, 6'h0, "zext half");
    for (int k = 11; k < 16; k++) begin
      run(bmp_op_t'(k), 64'hFFFF, 64'hFFFF, 6'h0, "bad code");
    end
    done();
    t_reset();
    run(OP_XNOR, 64'h0, 64'h1, 6'h0, "after reset");
    done();
    stop_test();
  end

  initial begin
    #(2000 * 50);
    miscompares++;
    stop_test();
  end
endmodule
